// ==== core/adcc_top.sv ====
// Purpose: control, sequencing and result registers of a 10-bit SAR
// Assumes: comparator and RC oscillator arrive asynchronously
// Notes: one clock, registers on a plain strobe port
//
// How it works
// - justify bit picks right or left layout
// - reference bit picks external pin or supply
// - channel field selects analog input 0..7
// - go bit starts, reads busy, self-clears
// - enable bit powers converter, else idle
// - clock field picks divider or RC source
// - RC source is independent oscillator, 500 kHz max
// - left layout: high 9..2, low top 1..0
// - right layout: high low 9..8, low 7..0
// - unimplemented control bits read zero
// - every completion sets flag, loads result
// - conversion lasts 11 conversion clock periods
// - abort keeps result, waits 2 periods
// - RC source delays start one instruction
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "adcc_cfg.svh"

module adcc_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cmp_in,
  input wire logic rc_osc_in,
  output adcc_pkg::adcc_ana_s ana_out,
  output logic irq
);

  localparam logic [3:0] INSTR_CYCLES = 4'(`ADCC_INSTR_CYCLES);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  adcc_pkg::adcc_state_e state_ff, nxt_state;
  logic [7:0] main_ff, nxt_main;
  logic [7:0] clksel_ff, nxt_clksel;
  logic [7:0] res_hi_ff, nxt_res_hi;
  logic [7:0] res_lo_ff, nxt_res_lo;
  logic done_flag_ff, nxt_done_flag;
  logic irq_en_ff, nxt_irq_en;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [5:0] div_ff, nxt_div;
  logic [3:0] wait_ff, nxt_wait;
  logic [9:0] code_ff, nxt_code;
  logic [9:0] mask_ff, nxt_mask;
  logic sample_ff, nxt_sample;
  logic cmp_s1_ff, cmp_s2_ff;
  logic rc_s1_ff, rc_s2_ff, rc_s3_ff;

  logic wr_main, go_wr, stop_wr, use_rc, tad_tick, div_tick, rc_tick;
  logic [5:0] div_last;
  logic [2:0] clk_field;

  // ----------------------------------------------------------------
  // synchronisers for the comparator and the RC oscillator
  // ----------------------------------------------------------------
  // the rc edge is taken between the second and third stage only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      rc_s1_ff <= 1'b0;
      rc_s2_ff <= 1'b0;
      rc_s3_ff <= 1'b0;
    end else begin
      cmp_s1_ff <= cmp_in;
      cmp_s2_ff <= cmp_s1_ff;
      rc_s1_ff <= rc_osc_in;
      rc_s2_ff <= rc_s1_ff;
      rc_s3_ff <= rc_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // conversion clock selection
  // ----------------------------------------------------------------
  // rc period stays near 2 us max rate, so sampling at 20 MHz is safe
  assign rc_tick = rc_s2_ff & ~rc_s3_ff;
  assign clk_field = clksel_ff[`ADCC_CLKF_HI:`ADCC_CLKF_LO];
  assign use_rc = &clk_field[1:0];
  // divide ratio 2 << (2*f[1:0] + f[2]): 2,8,32 then 4,16,64
  assign div_last = 6'((7'h2 << {clk_field[1:0], 1'b0}
                        << clk_field[2]) - 7'h1);
  assign div_tick = (div_ff == div_last);
  assign tad_tick = use_rc ? rc_tick : div_tick;

  // ----------------------------------------------------------------
  // register writes to the main control
  // ----------------------------------------------------------------
  assign wr_main = reg_wr && (reg_addr == `ADCC_OFS_MAIN_CONTROL);
  assign go_wr = wr_main && reg_wdata[`ADCC_GO_BIT];
  assign stop_wr = wr_main && !reg_wdata[`ADCC_GO_BIT];

  // ----------------------------------------------------------------
  // sequencer and successive approximation
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_div = div_tick ? 6'h00 : div_ff + 6'h01;
    nxt_wait = wait_ff;
    nxt_code = code_ff;
    nxt_mask = mask_ff;
    nxt_sample = sample_ff;
    nxt_main = main_ff;
    nxt_clksel = clksel_ff;
    nxt_res_hi = res_hi_ff;
    nxt_res_lo = res_lo_ff;
    nxt_done_flag = done_flag_ff;
    nxt_irq_en = irq_en_ff;
    // software register writes; reserved bits stay zero
    if (wr_main) begin
      nxt_main = (reg_wdata & `ADCC_MAIN_WMASK)
               | (main_ff & 8'h02);
    end
    if (reg_wr && reg_addr == `ADCC_OFS_CLOCK_SELECT) begin
      nxt_clksel = reg_wdata & `ADCC_CLKSEL_WMASK;
    end
    if (reg_wr && reg_addr == `ADCC_OFS_RESULT_HIGH) begin
      nxt_res_hi = reg_wdata;
    end
    if (reg_wr && reg_addr == `ADCC_OFS_RESULT_LOW) begin
      nxt_res_lo = reg_wdata;
    end
    if (reg_wr && reg_addr == `ADCC_OFS_IRQ_MASK) begin
      nxt_irq_en = reg_wdata[`ADCC_DONE_FLAG_BIT];
    end
    // write one clears; a completion below still wins
    if (reg_wr && reg_addr == `ADCC_OFS_IRQ_STATUS &&
        reg_wdata[`ADCC_DONE_FLAG_BIT]) begin
      nxt_done_flag = 1'b0;
    end
    case (state_ff)
      adcc_pkg::ADCC_IDLE: begin
        nxt_sample = main_ff[`ADCC_ENABLE_BIT];
        // start only with the converter already powered
        if (go_wr && main_ff[`ADCC_ENABLE_BIT]) begin
          nxt_main[`ADCC_GO_BIT] = 1'b1;
          nxt_wait = 4'h0;
          if (use_rc) begin
            nxt_state = adcc_pkg::ADCC_DELAY;
          end else begin
            nxt_state = adcc_pkg::ADCC_CONV;
            nxt_sample = 1'b0;
            nxt_div = 6'h00;
            nxt_mask = 10'h000;
            nxt_code = 10'h000;
          end
        end
      end
      adcc_pkg::ADCC_DELAY: begin
        nxt_wait = wait_ff + 4'h1;
        if (stop_wr || !nxt_main[`ADCC_ENABLE_BIT]) begin
          nxt_state = adcc_pkg::ADCC_IDLE;
          nxt_main[`ADCC_GO_BIT] = 1'b0;
        end else if (wait_ff == INSTR_CYCLES - 4'h1) begin
          nxt_state = adcc_pkg::ADCC_CONV;
          nxt_sample = 1'b0;
          nxt_mask = 10'h000;
          nxt_code = 10'h000;
        end
      end
      adcc_pkg::ADCC_CONV: begin
        if (stop_wr || !nxt_main[`ADCC_ENABLE_BIT]) begin
          // result registers keep the previous conversion
          nxt_state = adcc_pkg::ADCC_ABORT;
          nxt_main[`ADCC_GO_BIT] = 1'b0;
          nxt_wait = 4'h0;
        end else if (tad_tick) begin
          // first period holds the sample, then one bit per period
          if (mask_ff == 10'h000) begin
            nxt_code = 10'h200;
            nxt_mask = 10'h200;
          end else begin
            nxt_code = cmp_s2_ff ? code_ff : code_ff & ~mask_ff;
            nxt_mask = mask_ff >> 1;
            nxt_code = nxt_code | nxt_mask;
          end
          if (mask_ff == 10'h001) begin
            nxt_state = adcc_pkg::ADCC_IDLE;
            nxt_main[`ADCC_GO_BIT] = 1'b0;
            nxt_done_flag = 1'b1;
            // both bytes in the same cycle as go clears
            if (main_ff[`ADCC_JUSTIFY_BIT]) begin
              nxt_res_hi = {6'h00, nxt_code[9:8]};
              nxt_res_lo = nxt_code[7:0];
            end else begin
              nxt_res_hi = nxt_code[9:2];
              nxt_res_lo = {nxt_code[1:0], 6'h00};
            end
          end
        end
      end
      adcc_pkg::ADCC_ABORT: begin
        // go writes are ignored until the settle has passed
        nxt_main[`ADCC_GO_BIT] = 1'b0;
        if (tad_tick) begin
          nxt_wait = wait_ff + 4'h1;
          if (wait_ff == 4'(`ADCC_ABORT_PERIODS - 1)) begin
            nxt_state = adcc_pkg::ADCC_IDLE;
          end
        end
      end
      default: begin
        nxt_state = adcc_pkg::ADCC_IDLE;
        nxt_main[`ADCC_GO_BIT] = 1'b0;
      end
    endcase
  end

  // registering of all control and result state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= adcc_pkg::ADCC_IDLE;
      main_ff <= `ADCC_MAIN_RESET;
      clksel_ff <= `ADCC_CLKSEL_RESET;
      res_hi_ff <= `ADCC_RESULT_RESET;
      res_lo_ff <= `ADCC_RESULT_RESET;
      done_flag_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      div_ff <= 6'h00;
      wait_ff <= 4'h0;
      code_ff <= 10'h000;
      mask_ff <= 10'h000;
      sample_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      main_ff <= nxt_main;
      clksel_ff <= nxt_clksel;
      res_hi_ff <= nxt_res_hi;
      res_lo_ff <= nxt_res_lo;
      done_flag_ff <= nxt_done_flag;
      irq_en_ff <= nxt_irq_en;
      div_ff <= nxt_div;
      wait_ff <= nxt_wait;
      code_ff <= nxt_code;
      mask_ff <= nxt_mask;
      sample_ff <= nxt_sample;
    end
  end

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `ADCC_OFS_MAIN_CONTROL: nxt_rdata = main_ff;
        `ADCC_OFS_CLOCK_SELECT: nxt_rdata = clksel_ff;
        `ADCC_OFS_RESULT_HIGH: nxt_rdata = res_hi_ff;
        `ADCC_OFS_RESULT_LOW: nxt_rdata = res_lo_ff;
        `ADCC_OFS_IRQ_STATUS: nxt_rdata = {7'h00, done_flag_ff};
        `ADCC_OFS_IRQ_MASK: nxt_rdata = {7'h00, irq_en_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // everything the analog side sees comes straight from flip-flops
  assign reg_rdata = rdata_ff;
  assign irq = done_flag_ff & irq_en_ff;
  assign ana_out.power = main_ff[`ADCC_ENABLE_BIT];
  assign ana_out.ref_ext = main_ff[`ADCC_REFSEL_BIT];
  assign ana_out.channel =
    main_ff[`ADCC_CHAN_HI:`ADCC_CHAN_LO];
  assign ana_out.sample = sample_ff;
  assign ana_out.trial_code = code_ff;

endmodule

// ==== core/adcc_cfg.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 20 MHz system clock, byte-wide register port
// Notes: definitions only
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define ADCC_OFS_MAIN_CONTROL 3'h0
`define ADCC_OFS_CLOCK_SELECT 3'h1
`define ADCC_OFS_RESULT_HIGH 3'h2
`define ADCC_OFS_RESULT_LOW 3'h3
`define ADCC_OFS_IRQ_STATUS 3'h4
`define ADCC_OFS_IRQ_MASK 3'h5

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define ADCC_JUSTIFY_BIT 7
`define ADCC_REFSEL_BIT 6
`define ADCC_CHAN_HI 4
`define ADCC_CHAN_LO 2
`define ADCC_GO_BIT 1
`define ADCC_ENABLE_BIT 0
`define ADCC_CLKF_HI 6
`define ADCC_CLKF_LO 4
`define ADCC_DONE_FLAG_BIT 0

// ------------------------------------------------------------------
// reset values and write masks
// ------------------------------------------------------------------
`define ADCC_MAIN_RESET 8'h00
`define ADCC_CLKSEL_RESET 8'h00
`define ADCC_RESULT_RESET 8'h00
`define ADCC_MAIN_WMASK 8'hdd
`define ADCC_CLKSEL_WMASK 8'h70

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define ADCC_CLK_PERIOD_NS 50
`define ADCC_INSTR_CYCLE_NS 200
`define ADCC_INSTR_CYCLES \
  ((`ADCC_INSTR_CYCLE_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`define ADCC_CONV_PERIODS 11
`define ADCC_ABORT_PERIODS 2
`define ADCC_RC_MAX_KHZ 500

`endif

// ==== core/adcc_pkg.sv ====
// Purpose: shared types of the converter control block
// Assumes: constants live in adcc_cfg.svh
// Notes: types only
package adcc_pkg;

  // ----------------------------------------------------------------
  // sequencer states, gray along idle-delay-conv-abort
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCC_IDLE  = 2'h0,
    ADCC_DELAY = 2'h1,
    ADCC_CONV  = 2'h3,
    ADCC_ABORT = 2'h2
  } adcc_state_e;

  // ----------------------------------------------------------------
  // drive bundle towards the analog array
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power;
    logic ref_ext;
    logic [2:0] channel;
    logic sample;
    logic [9:0] trial_code;
  } adcc_ana_s;

endpackage

// ==== dv/adcc_checker.sv ====
// Purpose: port-level checks of the converter control block
// Assumes: one clock, async active-low reset
// Notes: bound to adcc_top at the foot of this file
`timescale 1ns/100ps
module adcc_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cmp_in,
  input wire logic rc_osc_in,
  input wire adcc_pkg::adcc_ana_s ana_out,
  input wire logic irq
);
  // main control write decode, shared by several checks
  logic wr_main;
  assign wr_main = reg_wr && reg_addr == 3'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  main_rsvd_a: assert property (
    $past(reg_rd && reg_addr == 3'h0) |-> !reg_rdata[5])
    else $error("main control bit 5 reads one");
  clk_rsvd_a: assert property (
    $past(reg_rd && reg_addr == 3'h1) |-> !reg_rdata[7] &&
    reg_rdata[3:0] == 4'h0)
    else $error("clock select reserved bits read one");
  unmapped_rd_a: assert property (
    $past(reg_rd && reg_addr > 3'h5) |-> reg_rdata == 8'h00)
    else $error("unmapped index reads nonzero");
  power_follow_a: assert property (
    wr_main |=> ana_out.power == $past(reg_wdata[0]))
    else $error("power does not follow enable bit");
  cfg_follow_a: assert property (
    wr_main |=> ana_out.ref_ext == $past(reg_wdata[6]) &&
    ana_out.channel == $past(reg_wdata[4:2]))
    else $error("reference or channel does not follow write");
  cfg_hold_a: assert property (
    !$past(wr_main) |-> $stable(ana_out.channel) &&
    $stable(ana_out.ref_ext) && $stable(ana_out.power))
    else $error("analog setup changed without a write");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(reg_wr && reg_addr inside {3'h4, 3'h5}))
    else $error("interrupt dropped without clear or mask");
  mask_off_a: assert property (
    reg_wr && reg_addr == 3'h5 && !reg_wdata[0] |=> !irq)
    else $error("interrupt high while masked");
endmodule

bind adcc_top adcc_checker chk_i (.clk(clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_in(cmp_in),
  .rc_osc_in(rc_osc_in), .ana_out(ana_out), .irq(irq));

// ==== dv/adcc_ana_model.sv ====
// Purpose: behavioural analog array, comparator against a held level
// Assumes: comparator answers as soon as the trial code changes
// Notes: output toggles every clock while unpowered
`timescale 1ns/100ps
module adcc_ana_model (
  input wire logic clk,
  input wire adcc_pkg::adcc_ana_s ana_out,
  input wire logic [9:0] level,
  output logic cmp_in
);
  logic tgl = 1'b0;
  // unpowered comparator gives no trustworthy answer
  always @(posedge clk) tgl <= ~tgl;
  // high while the held input is at or above the trial code
  assign cmp_in = ana_out.power ? level >= ana_out.trial_code : tgl;
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: 20 MHz clock, free rc source just under 500 kHz
// Notes: each scenario is one task
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic cmp_in;
  logic rc_osc_in = 1'b0;
  adcc_pkg::adcc_ana_s ana_out;
  logic irq;
  logic [9:0] level = 10'h000;
  int num_errors = 0;
  int cmp_count = 0;
  // odd half period keeps the rc source off the clock phase
  always #25 clk = ~clk;
  always #1003 rc_osc_in = ~rc_osc_in;
  adcc_top uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmp_in(cmp_in), .rc_osc_in(rc_osc_in),
    .ana_out(ana_out), .irq(irq));
  adcc_ana_model ana_i (.clk(clk), .ana_out(ana_out), .level(level),
    .cmp_in(cmp_in));
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  // bus cycles: one strobe cycle, read data the cycle after
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rchk(string n, logic [2:0] a, logic [7:0] m,
    logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, {2'h0, e & m}, {2'h0, d & m});
  endtask
  // reset values, reserved bits, channel routing, enable gate
  task automatic t_cfg();
    rchk("main rst", 3'h0, 8'hff, 8'h00);
    rchk("clk rst", 3'h1, 8'hff, 8'h00);
    rchk("unmapped", 3'h7, 8'hff, 8'h00);
    wr(3'h0, 8'hfd);
    wr(3'h1, 8'hff);
    rchk("main rsvd", 3'h0, 8'hff, 8'hdd);
    rchk("clk rsvd", 3'h1, 8'hff, 8'h70);
    chk("ref ext", 10'h1, {9'h0, ana_out.ref_ext});
    for (int c = 0; c < 8; c++) begin
      wr(3'h0, {3'h0, c[2:0], 2'h1});
      #1;
      chk("chan", {7'h0, c[2:0]}, {7'h0, ana_out.channel});
      chk("ref vdd", 10'h0, {9'h0, ana_out.ref_ext});
    end
    wr(3'h0, 8'h00);
    #1;
    chk("power off", 10'h0, {9'h0, ana_out.power});
    wr(3'h0, 8'h02);
    rchk("go refused", 3'h0, 8'h02, 8'h00);
    $display("cfg done");
  endtask
  // one conversion on source f in layout j
  task automatic t_conv(logic j, logic [2:0] f, logic [9:0] v);
    int n;
    int d;
    logic [7:0] h;
    logic [7:0] l;
    d = 2 << (2 * f[1:0] + f[2]);
    level <= v;
    wr(3'h1, {1'b0, f, 4'h0});
    wr(3'h0, {j, 7'h01});
    repeat (100) @(posedge clk);
    chk("sampling", 10'h1, {9'h0, ana_out.sample});
    wr(3'h0, {j, 7'h03});
    rchk("busy", 3'h0, 8'h02, 8'h02);
    n = 2;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    // switch stays open until the edge after completion
    chk("held", 10'h0, {9'h0, ana_out.sample});
    if (f[1:0] == 2'h3)
      chk("rc span", 10'h1, 10'(n > 400 && n < 560));
    else
      chk("span", 10'(11 * d), 10'(n));
    rchk("busy off", 3'h0, 8'h02, 8'h00);
    rchk("flag", 3'h4, 8'h01, 8'h01);
    rd(3'h2, h);
    rd(3'h3, l);
    if (j)
      chk("right", v, {h[1:0], l});
    else
      chk("left", v, {h, l[7:6]});
    wr(3'h4, 8'h01);
    rchk("flag clr", 3'h4, 8'h01, 8'h00);
    chk("irq clr", 10'h0, {9'h0, irq});
    $display("conv %0d %0d done", j, f);
  endtask
  // flag rises even with the interrupt masked off
  task automatic t_mask();
    // divide by 4, so the result kept here is a settled one
    wr(3'h5, 8'h00);
    wr(3'h1, 8'h40);
    wr(3'h0, 8'h81);
    repeat (100) @(posedge clk);
    wr(3'h0, 8'h83);
    repeat (60) @(posedge clk);
    chk("irq masked", 10'h0, {9'h0, irq});
    rchk("flag set", 3'h4, 8'h01, 8'h01);
    wr(3'h5, 8'h01);
    #1;
    chk("irq on", 10'h1, {9'h0, irq});
    wr(3'h4, 8'h01);
    $display("mask done");
  endtask
  // abort keeps the old result and holds off a restart
  task automatic t_abort();
    logic [9:0] old;
    old = level;
    level <= ~old;
    wr(3'h1, 8'h60);
    repeat (100) @(posedge clk);
    wr(3'h0, 8'h83);
    repeat (300) @(posedge clk);
    wr(3'h0, 8'h81);
    wr(3'h0, 8'h83);
    rchk("settle", 3'h0, 8'h02, 8'h00);
    rchk("res kept", 3'h3, 8'hff, old[7:0]);
    rchk("no flag", 3'h4, 8'h01, 8'h00);
    repeat (130) @(posedge clk);
    wr(3'h0, 8'h83);
    rchk("restart", 3'h0, 8'h02, 8'h02);
    wr(3'h0, 8'h81);
    $display("abort done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog, several times the expected run
  initial begin
    #1000000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_cfg();
    wr(3'h5, 8'h01);
    // divide by 2 is shorter than the comparator round trip through
    // the synchroniser, so only a full-scale level converts exactly
    for (int i = 0; i < 8; i++)
      t_conv(i[0], i[2:0], i == 0 ? 10'h3ff : 10'(i * 137 + 1));
    t_mask();
    t_abort();
    conclude();
  end
endmodule
